// [rcev_defines.vh]
// Purpose: constants and register map of the rx checksum and event block
// Assumes: byte addresses on a 16-bit wishbone address, 32-bit data
// Notes: included by rcev_rx_offload.v and by the test bench
// Overview of operation
// R1 - small-packet event when enabled and frame length <= 12-bit threshold
// R2 - stripped vlan tag bytes are not counted in the frame length
// R3 - 16-bit ack delay, each count lasting 1.024 us
// R4 - first ack while idle loads the countdown; interrupt only at expiry
// R5 - acks arriving during the countdown do not reload it
// R6 - ack delay of zero gives an immediate ack interrupt
// R7 - packet sum starts at the 8-bit start offset, after vlan stripping
// R8 - extended descriptor: sum and ip id when report-disable 0, else hash
// R9 - software never sets report-disable with legacy descriptors
// R10 - with payload mode clear, report raw 16-bit ones-complement sum
// R11 - crc bytes are left out of the packet sum when crc stripping is on
// R12 - ip offload bit 8 (reset 1) checks ipv4 header sum, flags error
// R13 - l4 offload bit 9 (reset 1) checks tcp/udp sum, flags error
// R14 - ipv6 l4 sums checked only if both ipv6 filter disables are clear
// R15 - checksum offload only for ethernet ii and snap frames
// R16 - software writes checksum control only with the receiver disabled
// R17 - software keeps the start offset at or before the ip header
// R18 - software backs out extra bytes and adds pseudo-header to raw sum
// R19 - small-packet and ack are separate causes, gated by their enables
`ifndef RCEV_DEFINES_VH
`define RCEV_DEFINES_VH
`define RCEV_ADR_THRESH 16'h2c00
`define RCEV_ADR_ADLY   16'h2c08
`define RCEV_ADR_CPU_VECTOR_RESERVED 16'h2c10
`define RCEV_ADR_ISTAT  16'h2c20
`define RCEV_ADR_ICLR   16'h2c24
`define RCEV_ADR_IEN    16'h2c28
`define RCEV_ADR_RXCTL  16'h2c2c
`define RCEV_ADR_CSUM   16'h5000
`define RCEV_CSUM_RST   16'h0300
`define RCEV_CSUM_WMSK  16'hf3ff
`define RCEV_RXCTL_WMSK 8'hf7
`define RCEV_CS_IP_HEADER_OFFLOAD_EN   8
`define RCEV_CS_L4_OFFLOAD_EN   9
`define RCEV_CS_IP_PAYLOAD_SUM_EN  12
`define RCEV_CS_CHECKSUM_REPORT_DISABLE    13
`define RCEV_RC_RXEN    0
`define RCEV_RC_SECRC   1
`define RCEV_RC_VME     2
`define RCEV_RC_V6DIS   6
`define RCEV_RC_V6SDIS  7
`define RCEV_INT_SMALL  0
`define RCEV_INT_ACK    1
`define RCEV_DTYP_EXT   2'h1
`define RCEV_TICK_NS    1024
`define RCEV_CLK_PS     8000
`define RCEV_TICK_CYC   ((`RCEV_TICK_NS * 1000) / `RCEV_CLK_PS)
`define RCEV_ET_MIN     16'h0600
`define RCEV_ET_V4      16'h0800
`define RCEV_ET_V6      16'h86dd
`define RCEV_SNAP_DSAP  8'haa
`define RCEV_SNAP_CTL   8'h03
`define RCEV_ETH_HDR    5'h0e
`define RCEV_SNAP_HDR   5'h16
`define RCEV_V6_HDR     6'h28
`define RCEV_PR_TCP     8'h06
`define RCEV_PR_UDP     8'h11
`define RCEV_TCP_FLAGS  6'h0d
`endif

// [rcev_rx_offload.v]
// Purpose: rx packet sum, ip/l4 checksum checks, small-packet and ack events
// Assumes: one byte per valid beat, sof/eof on the first/last byte
// Notes: mac marks vlan tag bytes and crc bytes with sideband flags
`timescale 1ns/1ps
`default_nettype none
`include "rcev_defines.vh"
module rcev_rx_offload (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [15:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        rx_valid_i,
  input  wire [7:0]  rx_data_i,
  input  wire        rx_sof_i,
  input  wire        rx_eof_i,
  input  wire        rx_vlan_i,
  input  wire        rx_fcs_i,
  output reg         desc_valid_o,
  output reg  [15:0] desc_csum_o,
  output reg  [15:0] desc_ip_id_o,
  output reg         desc_csum_sel_o,
  output reg         desc_ipcs_o,
  output reg         desc_ip_err_o,
  output reg         desc_l4cs_o,
  output reg         desc_l4_err_o,
  output reg         irq_o
);
  localparam integer TICK_CYC  = `RCEV_TICK_CYC;
  localparam [7:0]   TICK_LAST = TICK_CYC[7:0] - 8'h01;

  function [15:0] cs16;
    input [15:0] a;
    input [15:0] b;
    reg   [16:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      cs16 = s[15:0] + {15'h0, s[16]};
    end
  endfunction

  // even offsets carry the high byte of a word
  function [15:0] csb;
    input [15:0] a;
    input [7:0]  d;
    input        lo;
    begin
      csb = cs16(a, lo ? {8'h00, d} : {d, 8'h00});
    end
  endfunction

  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    reg   [31:0] m;
    begin
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      wmerge = (old & ~m) | (nw & m);
    end
  endfunction

  // software registers
  reg [11:0] thr_ff;
  reg [15:0] adly_ff;
  reg [15:0] csum_ff;
  reg [7:0]  rxctl_ff;
  reg [1:0]  en_ff;
  reg [1:0]  stat_ff;
  // ack countdown
  reg [7:0]  tick_ff;
  reg [15:0] cnt_ff;
  reg        run_ff;
  // frame parse state
  reg [13:0] pos_ff;
  reg [15:0] et_ff;
  reg        snap_ff;
  reg [1:0]  l3_ff;
  reg [4:0]  base_ff;
  reg [5:0]  hlen_ff;
  reg [15:0] lfld_ff;
  reg [7:0]  proto_ff;
  reg [15:0] id_ff;
  reg [15:0] ipsum_ff;
  reg [15:0] psum_ff;
  reg [15:0] l4sum_ff;
  reg [15:0] pkt_ff;
  reg        ackf_ff;
  reg        udpnz_ff;

  reg [13:0] nxt_pos;
  reg [15:0] nxt_et;
  reg        nxt_snap;
  reg [1:0]  nxt_l3;
  reg [4:0]  nxt_base;
  reg [5:0]  nxt_hlen;
  reg [15:0] nxt_lfld;
  reg [7:0]  nxt_proto;
  reg [15:0] nxt_id;
  reg [15:0] nxt_ipsum;
  reg [15:0] nxt_psum;
  reg [15:0] nxt_l4sum;
  reg [15:0] nxt_pkt;
  reg        nxt_ackf;
  reg        nxt_udpnz;

  reg        take;
  reg        fr;
  reg        v6;
  reg [13:0] p;
  reg [13:0] r;
  reg [13:0] l4rel;
  reg [13:0] start;
  reg [13:0] prel;
  reg [15:0] l4end;
  reg [15:0] l4len;
  reg [15:0] pse;
  reg        eof;
  reg        small_ev;
  reg        ack_ev;
  reg        ip_chk;
  reg        l4_chk;
  reg        l4_good;

  wire vme    = rxctl_ff[`RCEV_RC_VME];
  wire secrc  = rxctl_ff[`RCEV_RC_SECRC];
  wire ipp    = csum_ff[`RCEV_CS_IP_PAYLOAD_SUM_EN];
  // high type byte from the register, not the next value: no comb loop
  wire [15:0] et_now = {et_ff[15:8], rx_data_i};

  always @* begin
    // stripped tag bytes vanish from offsets and length
    take = rx_valid_i & ~(rx_vlan_i & vme) & rxctl_ff[`RCEV_RC_RXEN]; // R2 R7
    fr = take & rx_sof_i;
    nxt_pos   = fr ? 14'h0 : pos_ff;
    nxt_et    = fr ? 16'h0 : et_ff;
    nxt_snap  = fr ? 1'b0 : snap_ff;
    nxt_l3    = fr ? 2'h0 : l3_ff;
    nxt_base  = fr ? 5'h0 : base_ff;
    nxt_hlen  = fr ? `RCEV_V6_HDR : hlen_ff;
    nxt_lfld  = fr ? 16'h0 : lfld_ff;
    nxt_proto = fr ? 8'h0 : proto_ff;
    nxt_id    = fr ? 16'h0 : id_ff;
    nxt_ipsum = fr ? 16'h0 : ipsum_ff;
    nxt_psum  = fr ? 16'h0 : psum_ff;
    nxt_l4sum = fr ? 16'h0 : l4sum_ff;
    nxt_pkt   = fr ? 16'h0 : pkt_ff;
    nxt_ackf  = fr ? 1'b0 : ackf_ff;
    nxt_udpnz = fr ? 1'b0 : udpnz_ff;
    p = nxt_pos;
    v6 = 1'b0;
    r = 14'h0;
    l4rel = 14'h0;
    start = 14'h0;
    prel = 14'h0;
    l4end = 16'h0;
    if (take) begin
      nxt_pos = p + 14'h1;
      if (p == 14'd12 || p == 14'd20)
        nxt_et[15:8] = rx_data_i;
      if (p == 14'd13 || p == 14'd21)
        nxt_et[7:0] = rx_data_i;
      if (p == 14'd13)
        nxt_snap = et_now < `RCEV_ET_MIN;
      if (p >= 14'd14 && p <= 14'd19)
        nxt_snap = nxt_snap & (rx_data_i == (p < 14'd16 ? `RCEV_SNAP_DSAP :
                   (p == 14'd16 ? `RCEV_SNAP_CTL : 8'h00)));
      // only type-coded and snap frames get offload
      if ((p == 14'd13 && et_now >= `RCEV_ET_MIN) || (p == 14'd21 && nxt_snap)) begin // R15
        nxt_base = (p == 14'd13) ? `RCEV_ETH_HDR : `RCEV_SNAP_HDR;
        if (et_now == `RCEV_ET_V4)
          nxt_l3 = 2'h1;
        else if (et_now == `RCEV_ET_V6)
          nxt_l3 = 2'h2;
      end
      v6 = nxt_l3 == 2'h2;
      r = p - {9'h0, nxt_base};
      if (nxt_l3 != 2'h0 && p >= {9'h0, nxt_base}) begin
        if (r == 14'h0) begin
          if (rx_data_i[7:4] != (v6 ? 4'h6 : 4'h4))
            nxt_l3 = 2'h0;
          else if (!v6)
            nxt_hlen = {rx_data_i[3:0], 2'b00};
        end
        if (r == (v6 ? 14'h4 : 14'h2))
          nxt_lfld[15:8] = rx_data_i;
        if (r == (v6 ? 14'h5 : 14'h3))
          nxt_lfld[7:0] = rx_data_i;
        if (!v6 && r == 14'h4)
          nxt_id[15:8] = rx_data_i;
        if (!v6 && r == 14'h5)
          nxt_id[7:0] = rx_data_i;
        if (r == (v6 ? 14'h6 : 14'h9))
          nxt_proto = rx_data_i;
        if (!v6 && r < {8'h0, nxt_hlen})
          nxt_ipsum = csb(nxt_ipsum, rx_data_i, r[0]); // R12
        // addresses feed the pseudo-header
        if (v6 ? (r >= 14'd8 && r < 14'd40) : (r >= 14'd12 && r < 14'd20))
          nxt_psum = csb(nxt_psum, rx_data_i, r[0]); // R13 R14
        l4end = v6 ? nxt_lfld + {10'h0, `RCEV_V6_HDR} : nxt_lfld;
        l4rel = r - {8'h0, nxt_hlen};
        if (r >= {8'h0, nxt_hlen} && {2'h0, r} < l4end) begin
          nxt_l4sum = csb(nxt_l4sum, rx_data_i, r[0]); // R13
          if (nxt_proto == `RCEV_PR_TCP && l4rel == {8'h0, `RCEV_TCP_FLAGS})
            nxt_ackf = rx_data_i[4];
          if (nxt_proto == `RCEV_PR_UDP && (l4rel == 14'h6 || l4rel == 14'h7))
            nxt_udpnz = nxt_udpnz | (rx_data_i != 8'h00);
        end
      end
      // payload mode starts the raw sum at the l4 header
      if (ipp && nxt_l3 != 2'h0)
        start = {9'h0, nxt_base} + {8'h0, nxt_hlen};
      else
        start = {6'h0, csum_ff[7:0]}; // R7
      prel = p - start;
      if (p >= start && !(rx_fcs_i && secrc)) // R11
        nxt_pkt = csb(nxt_pkt, rx_data_i, prel[0]); // R10
    end
    eof = take & rx_eof_i;
    v6 = nxt_l3 == 2'h2;
    l4len = v6 ? nxt_lfld : nxt_lfld - {10'h0, nxt_hlen};
    pse = cs16(cs16(nxt_psum, {8'h0, nxt_proto}), l4len);
    // udp over ipv4 may omit its sum
    l4_good = cs16(nxt_l4sum, pse) == 16'hffff ||
              (!v6 && nxt_proto == `RCEV_PR_UDP && !nxt_udpnz);
    ip_chk = csum_ff[`RCEV_CS_IP_HEADER_OFFLOAD_EN] && nxt_l3 == 2'h1; // R12
    l4_chk = csum_ff[`RCEV_CS_L4_OFFLOAD_EN] && // R13
             (nxt_proto == `RCEV_PR_TCP || nxt_proto == `RCEV_PR_UDP) &&
             (nxt_l3 == 2'h1 || (v6 && !rxctl_ff[`RCEV_RC_V6DIS] &&
              !rxctl_ff[`RCEV_RC_V6SDIS])); // R14
    // length counts headers and crc
    small_ev = eof && (p + 14'h1) <= {2'h0, thr_ff}; // R1
    ack_ev = eof && nxt_l3 != 2'h0 && nxt_proto == `RCEV_PR_TCP && nxt_ackf;
  end

  // wishbone decode
  wire        req = wb_cyc_i & wb_stb_i;
  wire        wr  = req & wb_we_i & wb_ack_o;
  reg  [31:0] rdat;

  always @* begin
    case (wb_adr_i)
      `RCEV_ADR_THRESH: rdat = {20'h0, thr_ff};
      `RCEV_ADR_ADLY:   rdat = {16'h0, adly_ff};
      `RCEV_ADR_CSUM:   rdat = {16'h0, csum_ff};
      `RCEV_ADR_ISTAT:  rdat = {30'h0, stat_ff};
      `RCEV_ADR_IEN:    rdat = {30'h0, en_ff};
      `RCEV_ADR_RXCTL:  rdat = {24'h0, rxctl_ff};
      default:          rdat = 32'h0;
    endcase
  end

  wire [31:0] wd_thr   = wmerge({20'h0, thr_ff}, wb_dat_i, wb_sel_i);
  wire [31:0] wd_adly  = wmerge({16'h0, adly_ff}, wb_dat_i, wb_sel_i);
  wire [31:0] wd_csum  = wmerge({16'h0, csum_ff}, wb_dat_i, wb_sel_i);
  wire [31:0] wd_rxctl = wmerge({24'h0, rxctl_ff}, wb_dat_i, wb_sel_i);
  wire [31:0] wd_en    = wmerge({30'h0, en_ff}, wb_dat_i, wb_sel_i);
  wire [1:0]  clr = (wr && wb_adr_i == `RCEV_ADR_ICLR && wb_sel_i[0]) ?
                    wb_dat_i[1:0] : 2'h0;

  // ack timer: a running countdown is never restarted
  wire tick_last = tick_ff == TICK_LAST; // R3
  wire ack_start = ack_ev & en_ff[`RCEV_INT_ACK] & ~run_ff; // R5
  wire ack_fire  = (ack_start && adly_ff == 16'h0) || // R6
                   (run_ff && tick_last && cnt_ff == 16'h1); // R4
  wire [1:0] set;
  assign set[`RCEV_INT_SMALL] = small_ev & en_ff[`RCEV_INT_SMALL]; // R19
  assign set[`RCEV_INT_ACK]   = ack_fire & en_ff[`RCEV_INT_ACK]; // R19
  // set beats a same-cycle clear
  wire [1:0] nxt_stat = (stat_ff & ~clr) | set;

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      thr_ff   <= 12'h0;
      adly_ff  <= 16'h0;
      csum_ff  <= `RCEV_CSUM_RST;
      rxctl_ff <= 8'h0;
      en_ff    <= 2'h0;
      stat_ff  <= 2'h0;
      irq_o    <= 1'b0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      wb_dat_o <= (req & ~wb_ack_o & ~wb_we_i) ? rdat : 32'h0;
      if (wr && wb_adr_i == `RCEV_ADR_THRESH)
        thr_ff <= wd_thr[11:0];
      if (wr && wb_adr_i == `RCEV_ADR_ADLY)
        adly_ff <= wd_adly[15:0];
      if (wr && wb_adr_i == `RCEV_ADR_CSUM)
        csum_ff <= wd_csum[15:0] & `RCEV_CSUM_WMSK;
      if (wr && wb_adr_i == `RCEV_ADR_RXCTL)
        rxctl_ff <= wd_rxctl[7:0] & `RCEV_RXCTL_WMSK;
      if (wr && wb_adr_i == `RCEV_ADR_IEN)
        en_ff <= wd_en[1:0];
      stat_ff <= nxt_stat;
      irq_o   <= |(nxt_stat & en_ff);
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      tick_ff <= 8'h0;
      cnt_ff  <= 16'h0;
      run_ff  <= 1'b0;
    end else begin
      // prescaler restarts on load so the first count is a full period
      tick_ff <= (ack_start || tick_last) ? 8'h0 : tick_ff + 8'h1;
      if (ack_start && adly_ff != 16'h0) begin
        cnt_ff <= adly_ff; // R4
        run_ff <= 1'b1;
      end else if (run_ff && tick_last) begin
        cnt_ff <= cnt_ff - 16'h1;
        if (cnt_ff == 16'h1)
          run_ff <= 1'b0;
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      pos_ff   <= 14'h0;
      et_ff    <= 16'h0;
      snap_ff  <= 1'b0;
      l3_ff    <= 2'h0;
      base_ff  <= 5'h0;
      hlen_ff  <= 6'h0;
      lfld_ff  <= 16'h0;
      proto_ff <= 8'h0;
      id_ff    <= 16'h0;
      ipsum_ff <= 16'h0;
      psum_ff  <= 16'h0;
      l4sum_ff <= 16'h0;
      pkt_ff   <= 16'h0;
      ackf_ff  <= 1'b0;
      udpnz_ff <= 1'b0;
      desc_valid_o    <= 1'b0;
      desc_csum_o     <= 16'h0;
      desc_ip_id_o    <= 16'h0;
      desc_csum_sel_o <= 1'b0;
      desc_ipcs_o     <= 1'b0;
      desc_ip_err_o   <= 1'b0;
      desc_l4cs_o     <= 1'b0;
      desc_l4_err_o   <= 1'b0;
    end else begin
      pos_ff   <= nxt_pos;
      et_ff    <= nxt_et;
      snap_ff  <= nxt_snap;
      l3_ff    <= nxt_l3;
      base_ff  <= nxt_base;
      hlen_ff  <= nxt_hlen;
      lfld_ff  <= nxt_lfld;
      proto_ff <= nxt_proto;
      id_ff    <= nxt_id;
      ipsum_ff <= nxt_ipsum;
      psum_ff  <= nxt_psum;
      l4sum_ff <= nxt_l4sum;
      pkt_ff   <= nxt_pkt;
      ackf_ff  <= nxt_ackf;
      udpnz_ff <= nxt_udpnz;
      desc_valid_o <= eof;
      if (eof) begin
        desc_csum_o   <= nxt_pkt; // R10
        desc_ip_id_o  <= nxt_id;
        // legacy format always carries the sum; hash only when extended
        desc_csum_sel_o <= (rxctl_ff[5:4] == `RCEV_DTYP_EXT) ?
                           ~csum_ff[`RCEV_CS_CHECKSUM_REPORT_DISABLE] : 1'b1; // R8 R9
        desc_ipcs_o   <= ip_chk;
        desc_ip_err_o <= ip_chk && nxt_ipsum != 16'hffff; // R12
        desc_l4cs_o   <= l4_chk;
        desc_l4_err_o <= l4_chk && !l4_good; // R13 R14
      end
    end
  end
endmodule
`default_nettype wire

// [rcev_checker_assertions.sv]
// Purpose: port-level assertions for the rx offload block
// Assumes: one clock, synchronous active-high reset
// Notes: sees only the top ports, bound to every instance
`timescale 1ns/1ps
`default_nettype none
module rcev_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        rx_valid_i,
  input wire logic        rx_eof_i,
  input wire logic        desc_valid_o,
  input wire logic [15:0] desc_csum_o,
  input wire logic        desc_ipcs_o,
  input wire logic        desc_ip_err_o,
  input wire logic        desc_l4cs_o,
  input wire logic        desc_l4_err_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack cycle");
  a_desc_eof: assert property (desc_valid_o |-> $past(rx_valid_i && rx_eof_i))
    else $error("descriptor without a last byte");
  // fields must not drift between frames, software reads them late
  a_desc_hold: assert property (!desc_valid_o |-> $stable({desc_csum_o, desc_ip_err_o}))
    else $error("descriptor fields changed between frames");
  a_ip_err_chk: assert property (desc_ip_err_o |-> desc_ipcs_o)
    else $error("ip error flagged but header not checked");
  a_l4_err_chk: assert property (desc_l4_err_o |-> desc_l4cs_o)
    else $error("l4 error flagged but sum not checked");
  a_irq_fall: assert property ($fell(irq_o) |-> $past(wb_ack_o && wb_we_i))
    else $error("interrupt dropped without a register write");
endmodule
bind rcev_rx_offload rcev_checker chk_u (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o,
  .rx_valid_i, .rx_eof_i, .desc_valid_o, .desc_csum_o, .desc_ipcs_o,
  .desc_ip_err_o, .desc_l4cs_o, .desc_l4_err_o, .irq_o
);
`default_nettype wire

// [rcev_mac_model.sv]
// Purpose: byte-stream source standing in for the mac receive side
// Assumes: one byte per cycle, frames built in mem by mk
// Notes: data line shows the inverted last byte between frames
`timescale 1ns/1ps
`default_nettype none
module rcev_mac_model (
  input  wire logic       clk_i,
  output var  logic       rx_valid_o,
  output var  logic [7:0] rx_data_o,
  output var  logic       rx_sof_o,
  output var  logic       rx_eof_o,
  output var  logic       rx_vlan_o,
  output var  logic       rx_fcs_o
);
  logic [7:0] mem [0:127];
  initial {rx_valid_o, rx_data_o, rx_sof_o, rx_eof_o, rx_vlan_o, rx_fcs_o} = '0;
  function automatic logic [15:0] osum(input int a, input int b, input logic [31:0] x);
    logic [31:0] s;
    s = x;
    for (int i = a; i < b; i += 2)
      s += {mem[i], (i + 1 < b) ? mem[i + 1] : 8'h0};
    s = s[15:0] + s[31:16];
    return s[15:0] + s[16];
  endfunction
  // tcp over ipv4 in ethernet ii, crc counted in n
  task automatic mk(input int n, input logic [7:0] fl);
    for (int i = 0; i < n; i++) mem[i] = 8'(i * 29 + 3);
    {mem[12], mem[13], mem[14], mem[15]} = 32'h0800_4500;
    {mem[16], mem[17]} = 16'(n - 18);
    {mem[20], mem[21], mem[23]} = 24'h6;
    {mem[24], mem[25]} = 16'h0;
    {mem[24], mem[25]} = ~osum(14, 34, 0);
    {mem[46], mem[47], mem[50], mem[51]} = {8'h50, fl, 16'h0};
    {mem[50], mem[51]} = ~osum(34, n - 4, 32'(n - 38) + 32'h6 + osum(26, 34, 0));
  endtask
  // tcp over ipv6 without extension headers, tcp header at byte 54
  task automatic mk6(input int n);
    mk(n, 8'h10);
    {mem[12], mem[13], mem[14]} = 24'h86dd60;
    {mem[18], mem[19], mem[20]} = {16'(n - 58), 8'h06};
    {mem[70], mem[71]} = 16'h0;
    {mem[70], mem[71]} = ~osum(54, n - 4, 32'(n - 58) + 32'h6 + osum(22, 54, 0));
  endtask
  task automatic send(input int n, input bit vl, input bit fc);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_data_o  <= mem[i];
      rx_sof_o   <= i == 0;
      rx_eof_o   <= i == n - 1;
      rx_vlan_o  <= vl && i >= 12 && i < 16;
      rx_fcs_o   <= fc && i >= n - 4;
    end
    @(posedge clk_i);
    {rx_valid_o, rx_sof_o, rx_eof_o, rx_vlan_o, rx_fcs_o} <= '0;
    rx_data_o <= ~mem[n - 1];
  endtask
endmodule
`default_nettype wire

// [rcev_rx_checksum_and_event_detect_test.sv]
// Purpose: self-checking bench for the rx offload block
// Assumes: 125 MHz clock, wishbone classic register access
// Notes: expected sums come from the frame bytes, never the design
`timescale 1ns/1ps
`default_nettype none
`include "rcev_defines.vh"
module rcev_rx_checksum_and_event_detect_test;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_ack_o, irq_o;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [15:0] wb_adr_i = 16'h0, desc_csum_o, desc_ip_id_o;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic        rx_valid_i, rx_sof_i, rx_eof_i, rx_vlan_i, rx_fcs_i;
  logic [7:0]  rx_data_i;
  logic        desc_valid_o, desc_csum_sel_o, desc_ipcs_o, desc_ip_err_o;
  logic        desc_l4cs_o, desc_l4_err_o;
  int          mismatches = 0, samples_checked = 0, cycles = 0;
  rcev_rx_offload dut_u (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_valid_i, .rx_data_i, .rx_sof_i,
    .rx_eof_i, .rx_vlan_i, .rx_fcs_i, .desc_valid_o, .desc_csum_o,
    .desc_ip_id_o, .desc_csum_sel_o, .desc_ipcs_o, .desc_ip_err_o,
    .desc_l4cs_o, .desc_l4_err_o, .irq_o
  );
  rcev_mac_model mac_u (
    .clk_i, .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .rx_sof_o(rx_sof_i),
    .rx_eof_o(rx_eof_i), .rx_vlan_o(rx_vlan_i), .rx_fcs_o(rx_fcs_i)
  );
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, 4'hf, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    chk(n, 2);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // receiver off around the control write, extended descriptors only
  task automatic cfg(input logic [31:0] cs, input logic [31:0] rc);
    wr(`RCEV_ADR_RXCTL, rc & 32'hfe);
    wr(`RCEV_ADR_CSUM, cs);
    wr(`RCEV_ADR_RXCTL, rc);
  endtask
  task automatic rx(input int n, input bit vl);
    int k;
    mac_u.send(n, vl, 1'b1);
    for (k = 0; k < 8 && desc_valid_o !== 1'b1; k++) @(posedge clk_i);
    chk(k < 8, 1);
  endtask
  task automatic clr(input logic [31:0] m);
    wr(`RCEV_ADR_ICLR, m);
    @(posedge clk_i);
    chk(irq_o, 0);
  endtask
  task automatic wait_irq(input int lo, input int hi);
    int k;
    for (k = 0; k < hi && irq_o !== 1'b1; k++) @(posedge clk_i);
    chk(k >= lo && k < hi, 1);
  endtask
  task automatic t_regs();
    rd(`RCEV_ADR_CSUM, 32'h300);
    wr(`RCEV_ADR_CSUM, 32'hffff_dfff);
    rd(`RCEV_ADR_CSUM, 32'hd3ff);
    wr(`RCEV_ADR_THRESH, 32'hffff_ffff);
    rd(`RCEV_ADR_THRESH, 32'hfff);
    wr(`RCEV_ADR_ADLY, 32'hffff_ffff);
    rd(`RCEV_ADR_ADLY, 32'hffff);
    wr(`RCEV_ADR_CPU_VECTOR_RESERVED, 32'hffff_ffff);
    rd(`RCEV_ADR_CPU_VECTOR_RESERVED, 32'h0);
    rd(16'h0100, 32'h0);
    rd(`RCEV_ADR_ICLR, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_sum();
    mac_u.mk(70, 8'h00);
    cfg(32'h30e, 32'h13);
    rx(70, 0);
    chk(desc_csum_o, mac_u.osum(14, 66, 0));
    chk({desc_csum_sel_o, desc_ip_id_o}, {1'b1, mac_u.mem[18], mac_u.mem[19]});
    chk({desc_ipcs_o, desc_ip_err_o, desc_l4cs_o, desc_l4_err_o}, 4'b1010);
    mac_u.mem[24] ^= 8'h01;
    rx(70, 0);
    chk(desc_ip_err_o, 1);
    mac_u.mem[24] ^= 8'h01;
    mac_u.mem[60] ^= 8'h01;
    rx(70, 0);
    chk({desc_ip_err_o, desc_l4_err_o}, 2'b01);
    mac_u.mem[60] ^= 8'h01;
    cfg(32'h130e, 32'h13);
    rx(70, 0);
    chk(desc_csum_o, mac_u.osum(34, 66, 0));
    cfg(32'h20e, 32'h13);
    rx(70, 0);
    chk({desc_ipcs_o, desc_l4cs_o}, 2'b01);
    cfg(32'h10e, 32'h11);
    rx(70, 0);
    chk({desc_ipcs_o, desc_l4cs_o}, 2'b10);
    chk(desc_csum_o, mac_u.osum(14, 70, 0));
    cfg(32'h2300, 32'h11);
    rx(70, 0);
    chk(desc_csum_sel_o, 0);
    cfg(32'h300, 32'h11);
    {mac_u.mem[12], mac_u.mem[13]} = 16'h0040;
    rx(70, 0);
    chk(desc_csum_o, mac_u.osum(0, 70, 0));
    chk({desc_ipcs_o, desc_l4cs_o}, 2'b00);
    mac_u.mk6(100);
    cfg(32'h30e, 32'h13);
    rx(100, 0);
    chk({desc_ipcs_o, desc_ip_err_o, desc_l4cs_o, desc_l4_err_o}, 4'b0010);
    mac_u.mem[80] ^= 8'h01;
    rx(100, 0);
    chk(desc_l4_err_o, 1);
    cfg(32'h30e, 32'h53);
    rx(100, 0);
    chk(desc_l4cs_o, 0);
    $display("test sum done");
  endtask
  task automatic t_small();
    wr(`RCEV_ADR_THRESH, 32'd64);
    wr(`RCEV_ADR_IEN, 32'h1);
    cfg(32'h30e, 32'h13);
    for (int n = 64; n < 66; n++) begin
      mac_u.mk(n, 8'h00);
      rx(n, 0);
      chk(irq_o, n == 64);
      rd(`RCEV_ADR_ISTAT, n == 64);
      clr(32'h1);
    end
    cfg(32'h30e, 32'h17);
    mac_u.mk(68, 8'h00);
    rx(68, 1);
    chk(irq_o, 1);
    chk(desc_csum_o, mac_u.osum(18, 64, 0));
    clr(32'h1);
    wr(`RCEV_ADR_IEN, 32'h0);
    rx(68, 1);
    chk(irq_o, 0);
    rd(`RCEV_ADR_ISTAT, 32'h0);
    $display("test small done");
  endtask
  task automatic t_ack();
    wr(`RCEV_ADR_IEN, 32'h2);
    wr(`RCEV_ADR_ADLY, 32'h1);
    cfg(32'h30e, 32'h13);
    mac_u.mk(70, 8'h10);
    rx(70, 0);
    chk(irq_o, 0);
    wait_irq(100, 160);
    rd(`RCEV_ADR_ISTAT, 32'h2);
    clr(32'h2);
    wr(`RCEV_ADR_ADLY, 32'h2);
    rx(70, 0);
    repeat (80) @(posedge clk_i);
    rx(70, 0);
    chk(irq_o, 0);
    wait_irq(60, 160);
    clr(32'h2);
    wr(`RCEV_ADR_ADLY, 32'h0);
    rx(70, 0);
    chk(irq_o, 1);
    clr(32'h2);
    mac_u.mk(70, 8'h00);
    rx(70, 0);
    chk(irq_o, 0);
    $display("test ack done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_sum();
    t_small();
    t_ack();
    report_and_stop();
  end
endmodule
`default_nettype wire
